/* logic/serial_flash_core.sv */
// serial flash command core: reads, lock register access, page rewrite and program
// assumes an spi host on cs/sck/mosi; pins are sampled by i_clk, memory is flip-flops

// Summary of operation
// - read: opcode, three address bytes, data out
// - fast read inserts one dummy byte
// - address advances after each output byte
// - read address wraps to zero
// - chip select high ends output anytime
// - commands other than status read refused while a cycle runs
// - lock read returns addressed sector lock value
// - lock-down bit freezes both lock bits
// - write-lock bit blocks sector writes
// - rewrite/program need write enable latch set
// - rewrite keeps unsent bytes of page
// - data wraps inside the page
// - only last 256 bytes are kept
// - fewer bytes leave rest of page untouched
// - chip select off byte boundary discards command
// - valid end of unprotected rewrite/program starts timed cycle, busy set
// - write enable latch cleared before cycle ends
// - protected pages are not written
// - program only clears bits to zero
// - upper address bits beyond capacity ignored
// - status: busy bit0, latch bit1, read-only
module serial_flash_core
    import flash_pkg::*;
#(
    parameter int ADDR_W = flash_pkg::DEF_ADDR_W,
    parameter int REWRITE_CYCLES = flash_pkg::REWRITE_CYCLE_TIME_US * flash_pkg::CLK_MHZ,
    parameter int PROGRAM_CYCLES = flash_pkg::PROGRAM_CYCLE_TIME_US * flash_pkg::CLK_MHZ
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_hw_prot_en,
    input wire logic [ADDR_W-flash_pkg::PAGE_W-1:0] i_hw_prot_first_page,
    output logic o_busy,
    output logic o_wel
);
    import flash_pkg::*;

    // flop memory: fine for small parts, far too costly for a real array
    localparam int MEM_BYTES = 2 ** ADDR_W;
    localparam int SECTORS = 2 ** (ADDR_W - SECTOR_W);
    localparam int SEC_IDX_W = ADDR_W - SECTOR_W;
    localparam int PG_IDX_W = ADDR_W - PAGE_W;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    pin_ev_t cs_ev;
    pin_ev_t sck_ev;
    pin_ev_t mosi_ev;

    ctrl_t st_ff;
    ctrl_t nxt_st;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask;
    logic [1:0] lock_regs [SECTORS];

    logic buf_we;
    logic [PAGE_W-1:0] buf_idx;
    logic [7:0] buf_din;
    logic mask_clr;
    logic commit;
    logic lock_we;
    logic [1:0] lock_din;

    logic [7:0] byte_in;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] inc_addr;
    logic [SEC_IDX_W-1:0] cur_sec;
    logic [PG_IDX_W-1:0] cur_page;
    logic [7:0] status_byte;
    logic page_blocked;

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    pin_filter #(.INIT(1'b1)) u_cs (
        .i_clk(i_clk),
        .i_rstn(rst_n),
        .i_pin(i_cs_n),
        .o_ev(cs_ev)
    );
    pin_filter #(.INIT(1'b0)) u_sck (
        .i_clk(i_clk),
        .i_rstn(rst_n),
        .i_pin(i_sck),
        .o_ev(sck_ev)
    );
    pin_filter #(.INIT(1'b0)) u_mosi (
        .i_clk(i_clk),
        .i_rstn(rst_n),
        .i_pin(i_mosi),
        .o_ev(mosi_ev)
    );

    assign byte_in = {st_ff.in_sr[6:0], mosi_ev.level};
    assign cur_addr = st_ff.addr[ADDR_W-1:0];
    assign inc_addr = cur_addr + 1'b1;
    assign cur_sec = cur_addr[ADDR_W-1:SECTOR_W];
    assign cur_page = st_ff.page_addr[ADDR_W-1:PAGE_W];
    assign status_byte = {6'h0, st_ff.write_enable_latch, st_ff.busy};
    // write lock of the sector or hardware protection of the page
    assign page_blocked = lock_regs[st_ff.page_addr[ADDR_W-1:SECTOR_W]][LOCK_WRITE_BIT]
        | (i_hw_prot_en & (cur_page >= i_hw_prot_first_page));

    always_comb begin
        nxt_st = st_ff;
        buf_we = 1'b0;
        buf_idx = st_ff.addr[PAGE_W-1:0];
        buf_din = byte_in;
        mask_clr = 1'b0;
        commit = 1'b0;
        lock_we = 1'b0;
        lock_din = st_ff.in_sr[1:0];

        // self-timed cycle, status stays readable meanwhile
        if (st_ff.busy) begin
            if (st_ff.timer <= 32'h1) begin
                nxt_st.busy = 1'b0;
                commit = 1'b1;
            end else begin
                nxt_st.timer = st_ff.timer - 32'h1;
            end
        end

        if (cs_ev.rise) begin
            nxt_st.phase = PH_IDLE;
            nxt_st.miso_oe = 1'b0;
            if (st_ff.phase == PH_DATA && st_ff.bit_cnt == 3'h0 && st_ff.got_data) begin
                if (st_ff.opcode == OP_LOCK_REGISTER_WRITE_CMD) begin
                    // lock-down freezes both bits until reset
                    if (!lock_regs[cur_sec][LOCK_DOWN_BIT]) begin
                        lock_we = 1'b1;
                    end
                    nxt_st.write_enable_latch = 1'b0;
                end else begin
                    nxt_st.write_enable_latch = 1'b0;
                    if (!page_blocked) begin
                        nxt_st.busy = 1'b1;
                        nxt_st.timer = st_ff.rewrite ? 32'(REWRITE_CYCLES) : 32'(PROGRAM_CYCLES);
                    end
                end
            end else if (st_ff.phase == PH_WAITCS && st_ff.bit_cnt == 3'h0) begin
                nxt_st.write_enable_latch = 1'b1;
            end
            // any other ending point drops the command
        end else if (cs_ev.fall) begin
            nxt_st.phase = PH_OPCODE;
            nxt_st.bit_cnt = 3'h0;
            nxt_st.miso_oe = 1'b0;
            nxt_st.got_data = 1'b0;
        end else if (!cs_ev.level) begin
            // output phase counts falls only; counting rises too would halve each byte
            if (sck_ev.rise && st_ff.phase != PH_IDLE && st_ff.phase != PH_OUT) begin
                nxt_st.in_sr = byte_in;
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                if (st_ff.bit_cnt == 3'h7) begin
                    case (st_ff.phase)
                        PH_OPCODE: begin
                            nxt_st.opcode = byte_in;
                            nxt_st.addr_cnt = 2'h0;
                            // a status poll during a cycle must not change how it commits
                            if (!st_ff.busy) begin
                                nxt_st.rewrite = (byte_in == OP_PAGE_REWRITE_CMD);
                            end
                            if (byte_in == OP_STATUS_READ) begin
                                nxt_st.phase = PH_OUT;
                                nxt_st.out_sr = status_byte;
                            end else if (st_ff.busy) begin
                                nxt_st.phase = PH_IGNORE;
                            end else if (byte_in == OP_READ || byte_in == OP_FAST_READ
                                         || byte_in == OP_LOCK_REGISTER_READ_CMD) begin
                                nxt_st.phase = PH_ADDR;
                            end else if (byte_in == OP_PAGE_REWRITE_CMD || byte_in == OP_PAGE_PROGRAM_CMD
                                         || byte_in == OP_LOCK_REGISTER_WRITE_CMD) begin
                                // latch must be set by an earlier enable command
                                nxt_st.phase = st_ff.write_enable_latch ? PH_ADDR : PH_IGNORE;
                            end else if (byte_in == OP_WRITE_ENABLE_CMD) begin
                                nxt_st.phase = PH_WAITCS;
                            end else begin
                                nxt_st.phase = PH_IGNORE;
                            end
                        end
                        PH_ADDR: begin
                            nxt_st.addr = {st_ff.addr[ADDR_FULL_W-9:0], byte_in};
                            nxt_st.addr_cnt = st_ff.addr_cnt + 2'h1;
                            if (st_ff.addr_cnt == 2'(ADDR_BYTES - 1)) begin
                                case (st_ff.opcode)
                                    OP_READ: begin
                                        nxt_st.phase = PH_OUT;
                                        nxt_st.out_sr = mem[{st_ff.addr[ADDR_W-9:0], byte_in}];
                                    end
                                    OP_FAST_READ: begin
                                        nxt_st.phase = PH_DUMMY;
                                    end
                                    OP_LOCK_REGISTER_READ_CMD: begin
                                        nxt_st.phase = PH_OUT;
                                        nxt_st.out_sr = {6'h0,
                                            lock_regs[st_ff.addr[ADDR_W-9:SECTOR_W-8]]};
                                    end
                                    default: begin
                                        nxt_st.phase = PH_DATA;
                                        nxt_st.page_addr = {st_ff.addr[ADDR_FULL_W-9:0], byte_in};
                                        mask_clr = 1'b1;
                                    end
                                endcase
                            end
                        end
                        PH_DUMMY: begin
                            nxt_st.phase = PH_OUT;
                            nxt_st.out_sr = mem[cur_addr];
                        end
                        PH_DATA: begin
                            nxt_st.got_data = 1'b1;
                            if (st_ff.opcode == OP_LOCK_REGISTER_WRITE_CMD) begin
                                nxt_st.phase = PH_WAITCS;
                                nxt_st.in_sr = byte_in;
                            end else begin
                                // later bytes overwrite earlier ones at the same slot
                                buf_we = 1'b1;
                                nxt_st.addr[PAGE_W-1:0] = st_ff.addr[PAGE_W-1:0] + 8'h1;
                            end
                        end
                        PH_WAITCS: begin
                            nxt_st.phase = PH_IGNORE; // extra byte spoils a write enable; a lock write is back in data phase by then
                        end
                        default: begin
                            nxt_st.phase = st_ff.phase;
                        end
                    endcase
                end
            end
            // lock write ends after its data byte, still on a byte boundary
            if (st_ff.phase == PH_WAITCS && st_ff.opcode == OP_LOCK_REGISTER_WRITE_CMD) begin
                nxt_st.phase = (sck_ev.rise) ? PH_IGNORE : PH_DATA;
            end
            if (sck_ev.fall && st_ff.phase == PH_OUT) begin
                nxt_st.miso = st_ff.out_sr[7];
                nxt_st.miso_oe = 1'b1;
                nxt_st.out_sr = {st_ff.out_sr[6:0], 1'b0};
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                if (st_ff.bit_cnt == 3'h7) begin
                    case (st_ff.opcode)
                        OP_READ, OP_FAST_READ: begin
                            nxt_st.addr = {{(ADDR_FULL_W-ADDR_W){1'b0}}, inc_addr};
                            nxt_st.out_sr = mem[inc_addr];
                        end
                        OP_LOCK_REGISTER_READ_CMD: begin
                            nxt_st.out_sr = {6'h0, lock_regs[cur_sec]};
                        end
                        default: begin
                            nxt_st.out_sr = status_byte;
                        end
                    endcase
                end
            end
        end
        // output phase counts falling edges from a fresh start
        if (!cs_ev.level && sck_ev.rise && st_ff.phase != PH_OUT && st_ff.bit_cnt == 3'h7
            && nxt_st.phase == PH_OUT) begin
            nxt_st.bit_cnt = 3'h0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // data waits here so a discarded command never touches memory
    // page buffer and its per-byte written mask
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_mask <= '0;
        end else if (mask_clr) begin
            page_mask <= '0;
        end else if (buf_we) begin
            page_mask[buf_idx] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (buf_we) begin
            page_buf[buf_idx] <= buf_din;
        end
    end

    // lock registers are volatile: only reset clears lock-down
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < SECTORS; s++) begin
                lock_regs[s] <= LOCK_RESET;
            end
        end else if (lock_we) begin
            lock_regs[cur_sec] <= lock_din;
        end
    end

    // commit at the end of the timed cycle; erased at reset so reads are defined
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < MEM_BYTES; m++) begin
                mem[m] <= MEM_ERASED;
            end
        end else if (commit) begin
            for (int p = 0; p < PAGE_BYTES; p++) begin
                if (page_mask[p]) begin
                    if (st_ff.rewrite) begin
                        // erase plus write: unsent bytes come back unchanged
                        mem[{cur_page, PAGE_W'(p)}] <= page_buf[p];
                    end else begin
                        mem[{cur_page, PAGE_W'(p)}] <= mem[{cur_page, PAGE_W'(p)}] & page_buf[p];
                    end
                end
            end
        end
    end

    assign o_miso = st_ff.miso;
    // enable falls as soon as deselect is seen, even mid-byte
    assign o_miso_oe = st_ff.miso_oe & ~cs_ev.level;
    assign o_busy = st_ff.busy;
    assign o_wel = st_ff.write_enable_latch;
endmodule

/* logic/flash_pkg.sv */
// constants, state and carrier types shared by the serial flash command core
// assumes a single 100 MHz system clock and an spi mode 0/3 host
package flash_pkg;
    localparam int ADDR_FULL_W = 24;
    localparam int PAGE_W = 8;
    localparam int PAGE_BYTES = 256;
    localparam int SECTOR_W = 16;
    localparam int ADDR_BYTES = 3;
    localparam int CLK_MHZ = 100;
    localparam int REWRITE_CYCLE_TIME_US = 11000;
    localparam int PROGRAM_CYCLE_TIME_US = 800;
    localparam int DEF_ADDR_W = 18;

    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_LOCK_REGISTER_READ_CMD = 8'hE8;
    localparam logic [7:0] OP_LOCK_REGISTER_WRITE_CMD = 8'hE5;
    localparam logic [7:0] OP_PAGE_REWRITE_CMD = 8'h0A;
    localparam logic [7:0] OP_PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;

    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_WEL_BIT = 1;
    localparam int LOCK_WRITE_BIT = 0;
    localparam int LOCK_DOWN_BIT = 1;
    localparam logic [1:0] LOCK_RESET = 2'h0;
    localparam logic [7:0] MEM_ERASED = 8'hFF;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR,
        PH_DUMMY,
        PH_OUT,
        PH_DATA,
        PH_WAITCS,
        PH_IGNORE
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] opcode;
        logic [2:0] bit_cnt;
        logic [7:0] in_sr;
        logic [1:0] addr_cnt;
        logic [ADDR_FULL_W-1:0] addr;
        logic [7:0] out_sr;
        logic miso;
        logic miso_oe;
        logic write_enable_latch;
        logic busy;
        logic rewrite;
        logic [31:0] timer;
        logic got_data;
        logic [7:0] lock_data;
        logic [ADDR_FULL_W-1:0] page_addr;
    } ctrl_t;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } pin_ev_t;
endpackage

/* logic/pin_filter.sv */
// three-stage synchroniser with agreement filter and edge pulses
// assumes the pin is asynchronous to i_clk; reset is already synchronised
module pin_filter #(
    parameter logic INIT = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_pin,
    output flash_pkg::pin_ev_t o_ev
);
    import flash_pkg::*;

    logic [2:0] sync_ff;
    logic level_ff;
    logic nxt_level;

    // first stage feeds only the second
    always_comb begin
        nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[1] : level_ff;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_ff <= {3{INIT}};
            level_ff <= INIT;
        end else begin
            sync_ff <= {sync_ff[1:0], i_pin};
            level_ff <= nxt_level;
        end
    end

    assign o_ev.level = level_ff;
    assign o_ev.rise = nxt_level & ~level_ff;
    assign o_ev.fall = ~nxt_level & level_ff;
endmodule

/* verification/serial_flash_core_monitor.sv */
// checker of the serial flash core pin behaviour
// assumes bind onto serial_flash_core, host spi mode 0, sck slower than 8 clocks
module serial_flash_core_monitor
    import flash_pkg::*;
#(
    parameter int ADDR_W = flash_pkg::DEF_ADDR_W,
    parameter int REWRITE_CYCLES = flash_pkg::REWRITE_CYCLE_TIME_US * flash_pkg::CLK_MHZ,
    parameter int PROGRAM_CYCLES = flash_pkg::PROGRAM_CYCLE_TIME_US * flash_pkg::CLK_MHZ
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic i_hw_prot_en,
    input wire logic [ADDR_W-flash_pkg::PAGE_W-1:0] i_hw_prot_first_page,
    input wire logic o_busy,
    input wire logic o_wel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [31:0] busy_cnt_ff;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_cnt_ff <= '0;
        end else begin
            busy_cnt_ff <= o_busy ? busy_cnt_ff + 1 : '0;
        end
    end
    sequence cs_idle_s;
        i_cs_n [*8];
    endsequence
    sequence sck_held_s;
        !i_cs_n && o_miso_oe && i_sck && $past(i_sck, 3);
    endsequence
    oe_idle_a: assert property (cs_idle_s |-> !o_miso_oe) else $error("miso driven while deselected");
    oe_start_a: assert property ($rose(o_miso_oe) |-> !i_cs_n && !$past(i_cs_n, 3))
        else $error("miso enabled outside a frame");
    miso_hold_a: assert property (sck_held_s |-> $stable(o_miso)) else $error("miso moved in high sck");
    busy_start_a: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n))
        else $error("busy rose inside a frame");
    busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_ff >= PROGRAM_CYCLES - 2)
        else $error("timed cycle too short");
    busy_max_a: assert property (o_busy |-> busy_cnt_ff <= REWRITE_CYCLES + 2)
        else $error("timed cycle too long");
    wel_done_a: assert property ($fell(o_busy) |-> !o_wel) else $error("latch kept past cycle");
    busy_wel_a: assert property (o_busy |-> !o_wel) else $error("latch set while busy");
    wel_set_a: assert property ($rose(o_wel) |-> i_cs_n) else $error("latch set inside a frame");
endmodule

bind serial_flash_core serial_flash_core_monitor #(
    .ADDR_W(ADDR_W),
    .REWRITE_CYCLES(REWRITE_CYCLES),
    .PROGRAM_CYCLES(PROGRAM_CYCLES)
) u_mon (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_cs_n(i_cs_n),
    .i_sck(i_sck),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .i_hw_prot_en(i_hw_prot_en),
    .i_hw_prot_first_page(i_hw_prot_first_page),
    .o_busy(o_busy),
    .o_wel(o_wel)
);

/* verification/spi_host_model.sv */
// spi mode 0 host model: frames, msb-first bytes, 80 ns sck
// assumes a 100 MHz i_clk; all pins change on its falling edge
module spi_host_model (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end
    task automatic sel();
        @(negedge i_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    // nbits below 8 leaves the byte cut short on purpose
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, input int nbits = 8);
        for (int i = 7; i > 7 - nbits; i--) begin
            o_sck <= 1'b0;
            o_mosi <= d[i];
            repeat (4) @(negedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(negedge i_clk);
            q[i] = i_miso; // sampled just before the next fall
        end
    endtask
    task automatic desel();
        o_sck <= 1'b0;
        repeat (4) @(negedge i_clk);
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi; // released line: no stale level
        repeat (12) @(negedge i_clk);
    endtask
endmodule

/* verification/serial_flash_read_write_commands_tb.sv */
// self-checking bench of the serial flash core
// assumes spi_host_model as host and the monitor bound onto the core
module serial_flash_read_write_commands_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_pkg::*;
    localparam int AW = 18;
    logic i_clk = 1'b0, i_rstn = 1'b0, cs_n, sck, mosi, miso, miso_oe, busy, write_enable_latch;
    logic oe_seen = 1'b0, oe_clr = 1'b0;
    logic prot_en = 1'b0;
    logic [AW-9:0] prot_pg = 10'h002;
    logic [7:0] q;
    int n_errors = 0, n_checks = 0, cyc = 0;
    typedef struct packed {
        logic [7:0] op;
        logic [23:0] a;
        logic [7:0] d;
        logic [7:0] rop;
        logic [23:0] ra;
        logic [7:0] exp;
    } row_t;
    row_t rows[5] = '{
        '{8'h02, 24'h000010, 8'hA5, 8'h03, 24'h000010, 8'hA5},
        '{8'h02, 24'h000010, 8'h5A, 8'h0B, 24'h000010, 8'h00},
        '{8'h0A, 24'h000010, 8'h5A, 8'h03, 24'h000010, 8'h5A},
        '{8'h02, 24'hFC0011, 8'h3C, 8'h0B, 24'h000011, 8'h3C},
        '{8'h02, 24'h000000, 8'h81, 8'h03, 24'h000000, 8'h81}};
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        oe_seen <= (oe_seen | miso_oe) & ~oe_clr;
        if (cyc == 90000) begin
            n_errors++;
            close_out();
        end
    end
    spi_host_model host (.i_clk(i_clk), .i_miso(miso), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));
    serial_flash_core #(.ADDR_W(AW), .REWRITE_CYCLES(500), .PROGRAM_CYCLES(400)) DUT (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_sck(sck), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe(miso_oe), .i_hw_prot_en(prot_en), .i_hw_prot_first_page(prot_pg), .o_busy(busy), .o_wel(write_enable_latch));
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic hdr(input logic [7:0] op, input logic [23:0] a, input bit addr);
        host.sel();
        host.xfer(op, q);
        if (addr) for (int k = 2; k >= 0; k--) host.xfer(a[8*k+:8], q);
        if (op == 8'h0B) host.xfer(8'h00, q);
    endtask
    task automatic write1(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
        hdr(8'h06, 24'h0, 0);
        host.desel();
        hdr(op, a, 1);
        host.xfer(d, q);
        host.desel();
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] a);
        hdr(op, a, 1);
        host.xfer(8'hFF, q);
        host.desel();
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 700 && busy !== 1'b0; k++) @(negedge i_clk);
        chk(busy, 0);
    endtask
    task automatic reset_dut();
        @(negedge i_clk);
        i_rstn <= 1'b0;
        repeat (10) @(negedge i_clk);
        i_rstn <= 1'b1;
        repeat (10) @(negedge i_clk);
    endtask
    initial begin
        reset_dut();
        chk({busy, write_enable_latch, miso_oe}, 0);
        foreach (rows[r]) begin
            write1(rows[r].op, rows[r].a, rows[r].d);
            chk(busy, 1);
            wait_idle();
            chk(write_enable_latch, 0);
            rd(rows[r].rop, rows[r].ra);
            chk(q, rows[r].exp);
            $display("row %0d done", r);
        end
        hdr(8'h03, 24'h03FFFF, 1);
        host.xfer(8'hFF, q);
        chk(q, 8'hFF);
        host.xfer(8'hFF, q);
        chk(q, 8'h81);
        host.xfer(8'hFF, q, 3);
        host.desel();
        chk(miso_oe, 0);
        $display("stream test done");
        hdr(8'h06, 24'h0, 0);
        host.desel();
        hdr(8'h0A, 24'h0001FE, 1);
        for (int i = 0; i < 258; i++) host.xfer(i[7:0], q);
        host.desel();
        wait_idle();
        hdr(8'h0B, 24'h000100, 1);
        for (int o = 0; o < 256; o++) begin
            host.xfer(8'hFF, q);
            chk(q, 8'(o + 2));
        end
        host.desel();
        $display("page wrap test done");
        hdr(8'h02, 24'h000030, 1);
        host.xfer(8'h00, q);
        host.desel();
        chk(busy, 0);
        hdr(8'h06, 24'h0, 0);
        host.desel();
        hdr(8'h02, 24'h000030, 1);
        host.xfer(8'h00, q);
        host.xfer(8'h00, q, 3);
        host.desel();
        chk({busy, write_enable_latch}, 8'h01);
        prot_en <= 1'b1;
        write1(8'h02, 24'h000200, 8'h00);
        chk(busy, 0);
        prot_en <= 1'b0;
        rd(8'h03, 24'h000200);
        chk(q, 8'hFF);
        $display("refusal tests done");
        write1(8'h02, 24'h000020, 8'h0F);
        hdr(8'h05, 24'h0, 0);
        host.xfer(8'hFF, q);
        host.desel();
        chk(q, 8'h01);
        oe_clr <= 1'b1;
        @(negedge i_clk);
        oe_clr <= 1'b0;
        rd(8'h03, 24'h000020);
        chk(oe_seen, 0);
        wait_idle();
        rd(8'h03, 24'h000020);
        chk(q, 8'h0F);
        write1(8'h0A, 24'h000020, 8'hF0);
        hdr(8'h05, 24'h0, 0);
        host.xfer(8'hFF, q);
        host.desel();
        chk(q, 8'h01);
        wait_idle();
        rd(8'h03, 24'h000020);
        chk(q, 8'hF0);
        $display("busy test done");
        write1(8'hE5, 24'h010000, 8'h01);
        rd(8'hE8, 24'h01ABCD);
        chk(q, 8'h01);
        write1(8'h02, 24'h010000, 8'h00);
        chk(busy, 0);
        write1(8'hE5, 24'h010000, 8'h03);
        write1(8'hE5, 24'h010000, 8'h00);
        rd(8'hE8, 24'h010000);
        chk(q, 8'h03);
        rd(8'h03, 24'h010000);
        chk(q, 8'hFF);
        reset_dut();
        rd(8'hE8, 24'h010000);
        chk(q, 8'h00);
        $display("lock and reset test done");
        close_out();
    end
endmodule
